// >>> rtl/tof_sensor_i2c_target_port.sv
// Behaviour
// - Answer only bus address 0x52 family
// - Low address bit selects write or read
// - Each byte is followed by one ack
// - Sample data on rising serial clock
// - Data edges under high clock: start/stop
// - Acknowledge own address, keep direction bit
// - First two written bytes after address form index
// - Shift, store written byte, then acknowledge
// - Load register, shift out on falling edge
// - Receiver acknowledges every byte except the last read byte, which ends the read
// - Index advances by one per data byte
// - Only pull lines low, else release
// - Suppress glitches of 50 ns or less
// - Port reset pulse resets port only
// - Enable low disables port entirely
`timescale 1ns/1ps
module tof_sensor_i2c_target_port
  import tof_i2c_pkg::*;
#(
  parameter int REG_DEPTH = 256
)(
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                nrst_i,
  // Link pins and port controls.
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe_o,
  input  wire logic                port_reset_i,
  input  wire logic                comms_enable_in_i,
  // Status.
  output logic                     busy_o,
  output logic [INDEX_W-1:0]       index_o
);
  localparam int AW = $clog2(REG_DEPTH);

  initial
  begin
    if (REG_DEPTH < 2 || REG_DEPTH > (1 << INDEX_W))
      $error("REG_DEPTH out of range");
  end

  // Three-stage synchronisers on every pin input.
  logic [2:0] scl_s_reg;
  logic [2:0] sda_s_reg;
  logic [2:0] rst_s_reg;
  logic [2:0] en_s_reg;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      scl_s_reg <= 3'h7;
      sda_s_reg <= 3'h7;
      rst_s_reg <= 3'h0;
      en_s_reg  <= 3'h0;
    end
    else
    begin
      scl_s_reg <= {scl_s_reg[1:0], scl_i};
      sda_s_reg <= {sda_s_reg[1:0], sda_i};
      rst_s_reg <= {rst_s_reg[1:0], port_reset_i};
      en_s_reg  <= {en_s_reg[1:0], comms_enable_in_i};
    end
  end

  // Filtered levels follow a line once it is stable longer than a spike.
  logic       scl_f_reg;
  logic       sda_f_reg;
  logic       scl_f_d_reg;
  logic       sda_f_d_reg;
  logic [3:0] scl_cnt_reg;
  logic [3:0] sda_cnt_reg;
  logic       prst_reg;
  logic       en_reg;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      scl_f_reg   <= 1'b1;
      sda_f_reg   <= 1'b1;
      scl_cnt_reg <= 4'h0;
      sda_cnt_reg <= 4'h0;
    end
    else
    begin
      if ((scl_s_reg[2] == scl_s_reg[1]) && (scl_s_reg[2] != scl_f_reg))
      begin
        if (scl_cnt_reg >= 4'(SPIKE_CYC))
        begin
          scl_f_reg   <= scl_s_reg[2];
          scl_cnt_reg <= 4'h0;
        end
        else
          scl_cnt_reg <= scl_cnt_reg + 4'h1;
      end
      else
        scl_cnt_reg <= 4'h0;
      if ((sda_s_reg[2] == sda_s_reg[1]) && (sda_s_reg[2] != sda_f_reg))
      begin
        if (sda_cnt_reg >= 4'(SPIKE_CYC))
        begin
          sda_f_reg   <= sda_s_reg[2];
          sda_cnt_reg <= 4'h0;
        end
        else
          sda_cnt_reg <= sda_cnt_reg + 4'h1;
      end
      else
        sda_cnt_reg <= 4'h0;
    end
  end

  // Delayed filtered levels and agreed control levels.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      scl_f_d_reg <= 1'b1;
      sda_f_d_reg <= 1'b1;
      prst_reg    <= 1'b0;
      en_reg      <= 1'b0;
    end
    else
    begin
      scl_f_d_reg <= scl_f_reg;
      sda_f_d_reg <= sda_f_reg;
      if (rst_s_reg[2] == rst_s_reg[1])
        prst_reg <= rst_s_reg[2];
      if (en_s_reg[2] == en_s_reg[1])
        en_reg <= en_s_reg[2];
    end
  end

  // Line events seen after filtering.
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic port_off;
  assign scl_rise = scl_f_reg && !scl_f_d_reg;
  assign scl_fall = !scl_f_reg && scl_f_d_reg;
  assign start_ev = scl_f_reg && scl_f_d_reg && sda_f_d_reg && !sda_f_reg;
  assign stop_ev  = scl_f_reg && scl_f_d_reg && !sda_f_d_reg && sda_f_reg;
  assign port_off = prst_reg || !en_reg;

  // Transfer state.
  phase_t             phase_reg;
  phase_t             after_ack_reg;
  logic [BYTE_W-1:0]  shift_reg;
  logic [3:0]         bit_cnt_reg;
  logic               dir_rd_reg;
  logic               drive_low_reg;
  logic [INDEX_W-1:0] index_reg;
  logic [BYTE_W-1:0]  mem_reg [REG_DEPTH];
  logic [BYTE_W-1:0]  rx_byte;
  logic               byte_done;
  assign rx_byte   = {shift_reg[BYTE_W-2:0], sda_f_reg};
  assign byte_done = scl_rise && (bit_cnt_reg == 4'(BYTE_W - 1));

  // Serial engine: bit counting, address match, index and data transfer.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      phase_reg     <= ST_IDLE;
      after_ack_reg <= ST_IDLE;
      shift_reg     <= 8'h00;
      bit_cnt_reg   <= 4'h0;
      dir_rd_reg    <= 1'b0;
      drive_low_reg <= 1'b0;
      index_reg     <= INDEX_RST;
    end
    else if (port_off)
    begin
      phase_reg     <= ST_IDLE;
      bit_cnt_reg   <= 4'h0;
      drive_low_reg <= 1'b0;
      if (prst_reg)
        index_reg <= INDEX_RST;
    end
    else if (start_ev)
    begin
      phase_reg     <= ST_ADDR;
      bit_cnt_reg   <= 4'h0;
      drive_low_reg <= 1'b0;
    end
    else if (stop_ev)
    begin
      phase_reg     <= ST_IDLE;
      drive_low_reg <= 1'b0;
    end
    else
    begin
      unique case (phase_reg)
        ST_IDLE:
        begin
          drive_low_reg <= 1'b0;
        end
        ST_ADDR, ST_IDX_HI, ST_IDX_LO, ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (byte_done)
          begin
            bit_cnt_reg <= 4'h0;
            phase_reg   <= ST_ACK;
            if (phase_reg == ST_ADDR)
            begin
              if ((rx_byte & ~DIR_MASK) == DEV_ADDR_WR)
              begin
                dir_rd_reg    <= rx_byte[0];
                after_ack_reg <= rx_byte[0] ? ST_RDATA : ST_IDX_HI;
              end
              else
                phase_reg <= ST_IDLE;
            end
            else if (phase_reg == ST_IDX_HI)
            begin
              index_reg[15:8] <= rx_byte;
              after_ack_reg   <= ST_IDX_LO;
            end
            else if (phase_reg == ST_IDX_LO)
            begin
              index_reg[7:0] <= rx_byte;
              after_ack_reg  <= ST_WDATA;
            end
            else
            begin
              // Write data: the byte lands at the old index this edge.
              after_ack_reg <= ST_WDATA;
              index_reg     <= index_reg + 16'h0001;
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            // Pull the line low for the ack bit; after it, release on writes or drive the first read bit.
            drive_low_reg <= !drive_low_reg;
            if (drive_low_reg)
            begin
              phase_reg <= after_ack_reg;
              if (dir_rd_reg)
              begin
                shift_reg     <= mem_reg[index_reg[AW-1:0]];
                drive_low_reg <= !mem_reg[index_reg[AW-1:0]][BYTE_W-1];
              end
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'(BYTE_W - 1))
            begin
              drive_low_reg <= 1'b0;
              bit_cnt_reg   <= 4'h0;
              phase_reg     <= ST_MACK;
              index_reg     <= index_reg + 16'h0001;
            end
            else
            begin
              shift_reg     <= {shift_reg[BYTE_W-2:0], 1'b0};
              drive_low_reg <= !shift_reg[BYTE_W-2];
            end
          end
        end
        ST_MACK:
        begin
          // A missing controller ack ends the read; an ack reloads.
          if (scl_rise && sda_f_reg)
            phase_reg <= ST_IDLE;
          else if (scl_fall)
          begin
            phase_reg     <= ST_RDATA;
            shift_reg     <= mem_reg[index_reg[AW-1:0]];
            drive_low_reg <= !mem_reg[index_reg[AW-1:0]][BYTE_W-1];
          end
        end
        default:
        begin
          phase_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Storage of written bytes, taken when the byte ack starts.
  always_ff @(posedge clk_i)
  begin
    if (!port_off && !start_ev && !stop_ev && (phase_reg == ST_WDATA)
        && byte_done)
      mem_reg[index_reg[AW-1:0]] <= rx_byte;
  end

  // Registered outputs; the data pin only ever pulls low.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
      busy_o   <= 1'b0;
      index_o  <= INDEX_RST;
    end
    else
    begin
      sda_o    <= 1'b0;
      sda_oe_o <= drive_low_reg && !port_off;
      busy_o   <= (phase_reg != ST_IDLE);
      index_o  <= index_reg;
    end
  end

  // A matching address byte enters the ack phase on the next clock.
  property p_addr_ack;
    @(posedge clk_i) disable iff (!nrst_i)
    (phase_reg == ST_ADDR && byte_done && !start_ev && !stop_ev && !port_off
     && ((rx_byte & ~DIR_MASK) == DEV_ADDR_WR)) |=> (phase_reg == ST_ACK);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("no ack phase");

  // A foreign address returns the port to idle.
  property p_addr_miss;
    @(posedge clk_i) disable iff (!nrst_i)
    (phase_reg == ST_ADDR && byte_done && !start_ev && !stop_ev && !port_off
     && ((rx_byte & ~DIR_MASK) != DEV_ADDR_WR)) |=> (phase_reg == ST_IDLE);
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign addr");

  // Disabled port never drives the line.
  property p_off_quiet;
    @(posedge clk_i) disable iff (!nrst_i)
    port_off |=> !sda_oe_o;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("drove while off");

  // Driven level is always low.
  property p_low_only;
    @(posedge clk_i) disable iff (!nrst_i)
    sda_oe_o |-> (sda_o == 1'b0);
  endproperty
  a_low_only: assert property (p_low_only) else $error("drove high");

  // Start condition opens address phase whenever the port is on.
  property p_start;
    @(posedge clk_i) disable iff (!nrst_i)
    (start_ev && !port_off) |=> (phase_reg == ST_ADDR) && (bit_cnt_reg == 0);
  endproperty
  a_start: assert property (p_start) else $error("start missed");

  // Stop condition always idles the port.
  property p_stop;
    @(posedge clk_i) disable iff (!nrst_i)
    (stop_ev && !start_ev && !port_off) |=> (phase_reg == ST_IDLE);
  endproperty
  a_stop: assert property (p_stop) else $error("stop missed");

  // Read byte completion advances the index by one.
  property p_rd_inc;
    @(posedge clk_i) disable iff (!nrst_i)
    (phase_reg == ST_RDATA && scl_fall && bit_cnt_reg == 4'h7 && !port_off
     && !start_ev && !stop_ev) |=> (index_reg == $past(index_reg) + 16'h1);
  endproperty
  a_rd_inc: assert property (p_rd_inc) else $error("no read incr");

  // A stored write byte advances the index by one.
  property p_wr_inc;
    @(posedge clk_i) disable iff (!nrst_i)
    (phase_reg == ST_WDATA && byte_done && !port_off && !start_ev
     && !stop_ev) |=> (index_reg == $past(index_reg) + 16'h1);
  endproperty
  a_wr_inc: assert property (p_wr_inc) else $error("no write incr");

  // The clock fall after a controller ack starts the next read byte.
  property p_rd_next;
    @(posedge clk_i) disable iff (!nrst_i)
    (phase_reg == ST_MACK && scl_fall && !port_off && !start_ev
     && !stop_ev) |=> (phase_reg == ST_RDATA);
  endproperty
  a_rd_next: assert property (p_rd_next) else $error("no next byte");

  // Port reset clears index.
  property p_port_rst;
    @(posedge clk_i) disable iff (!nrst_i)
    prst_reg |=> (index_reg == INDEX_RST) ##1 (index_o == INDEX_RST);
  endproperty
  a_port_rst: assert property (p_port_rst) else $error("reset missed");
endmodule

// >>> rtl/tof_i2c_pkg.sv
package tof_i2c_pkg;

  // Bus address byte with the direction bit clear, and the direction mask.
  localparam logic [7:0] DEV_ADDR_WR = 8'h52;
  localparam logic [7:0] DIR_MASK    = 8'h01;

  // Widths of the serial unit and of the register index.
  localparam int BYTE_W  = 8;
  localparam int INDEX_W = 16;

  // Reset value of the register index.
  localparam logic [15:0] INDEX_RST = 16'h0000;

  // Glitch filter figure and the system clock rate.
  localparam int CLK_PERIOD_PS = 25000;
  localparam int SPIKE_PS      = 50000;
  localparam int SPIKE_CYC     = (SPIKE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Link-side serial clock limit.
  localparam int SCL_MAX_KHZ = 1000;

  // Transfer phases of the target port.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_IDX_HI,
    ST_IDX_LO,
    ST_WDATA,
    ST_RDATA,
    ST_ACK,
    ST_MACK
  } phase_t;

endpackage

// >>> test/i2c_host_model.sv
`timescale 1ns/1ps
// Bus controller model: makes the serial clock and pulls data low.
module i2c_host_model #(
  parameter int H = 20
)(
  // Clock and wire level.
  input  wire logic clk_i,
  input  wire logic sda_i,
  // Open-drain drives.
  output logic      scl_o,
  output logic      sda_pull_o
);
  // Clock stands high and data is released outside frames.
  initial
  begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  // Waits a number of system clock falling edges.
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Start or repeated start; a 2H bit keeps the clock at 1000 kHz.
  task automatic start();
    tick(H / 2);
    sda_pull_o = 1'b0;
    tick(H / 2);
    scl_o = 1'b1;
    tick(H);
    sda_pull_o = 1'b1;
    tick(H);
    scl_o = 1'b0;
  endtask

  // Stop: data rises while the clock is high.
  task automatic stop();
    tick(H / 2);
    sda_pull_o = 1'b1;
    tick(H / 2);
    scl_o = 1'b1;
    tick(H);
    sda_pull_o = 1'b0;
    tick(H);
  endtask

  // One bit; data changes only while the clock is low.
  task automatic bit_x(input logic b, output logic r);
    tick(H / 2);
    sda_pull_o = ~b;
    tick(H / 2);
    scl_o = 1'b1;
    tick(H);
    r = sda_i;
    scl_o = 1'b0;
  endtask

  // Sends a byte MSB first and returns the target's acknowledge.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  // Reads a byte; the last one is not acknowledged.
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
  import tof_i2c_pkg::*;
  logic               clk_i;
  logic               nrst_i;
  logic               port_reset_i;
  logic               comms_enable_in_i;
  logic               glitch;
  logic               scl;
  logic               pull;
  logic               sda_o;
  logic               sda_oe_o;
  logic               busy_o;
  logic [INDEX_W-1:0] index_o;
  wire logic          sda_w;
  int                 fail_count = 0;
  int                 compares = 0;
  logic               ack;
  logic [7:0]         d;

  // System clock at 40 MHz.
  initial
    clk_i = 1'b0;
  always #12.5 clk_i = ~clk_i;

  // Wire level from all pull-downs; the pull-up gives the high.
  assign sda_w = ~(pull | glitch | (sda_oe_o & ~sda_o));

  tof_sensor_i2c_target_port i_tof_sensor_i2c_target_port (
    .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .port_reset_i(port_reset_i),
    .comms_enable_in_i(comms_enable_in_i), .busy_o(busy_o),
    .index_o(index_o));

  i2c_host_model #(.H(20)) i_i2c_host_model (
    .clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(pull));

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Compares a value and reports a mismatch.
  task automatic chk(input logic [15:0] got, exp, input string m);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Sends a byte and checks the acknowledge against the expectation.
  task automatic send(input logic [7:0] b, input logic exp);
    i_i2c_host_model.wr_byte(b, ack);
    chk({15'h0, ack}, {15'h0, exp}, "ack");
  endtask

  // Addresses the port for writing and sends a 16-bit index.
  task automatic set_idx(input logic [15:0] idx);
    i_i2c_host_model.start();
    send(DEV_ADDR_WR, 1'b1);
    send(idx[15:8], 1'b1);
    send(idx[7:0], 1'b1);
  endtask

  // Waits a bounded time for the port to go idle.
  task automatic wait_idle();
    int n;
    for (n = 0; n < 100 && busy_o !== 1'b0; n++)
      @(negedge clk_i);
    chk({15'h0, busy_o}, 16'h0, "busy after stop");
    if (busy_o !== 1'b0)
      tally_and_finish();
  endtask

  // Writes three bytes across the storage boundary.
  task automatic t_write();
    set_idx(16'h00fe);
    send(8'ha5, 1'b1);
    send(8'h5a, 1'b1);
    chk({15'h0, sda_o}, 16'h0, "drive level");
    send(8'hc3, 1'b1);
    i_i2c_host_model.stop();
    wait_idle();
    chk(index_o, 16'h0101, "index after write");
    $display("t_write done");
  endtask

  // Reads back n bytes from 0x00fe after a repeated start.
  task automatic t_read(input int n);
    logic [7:0] exp[3] = '{8'ha5, 8'h5a, 8'hc3};
    set_idx(16'h00fe);
    i_i2c_host_model.start();
    send(DEV_ADDR_WR | DIR_MASK, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      i_i2c_host_model.rd_byte(i == n - 1, d);
      chk({8'h0, d}, {8'h0, exp[i]}, "read data");
    end
    i_i2c_host_model.stop();
    wait_idle();
    chk(index_o, 16'h00fe + 16'(n), "index after read");
    $display("t_read done");
  endtask

  // Foreign addresses get no acknowledge and leave the index alone.
  task automatic t_foreign();
    logic [7:0] a[4] = '{8'h50, 8'h54, 8'hd2, 8'h53};
    for (int i = 0; i < 3; i++)
    begin
      i_i2c_host_model.start();
      send(a[i], 1'b0);
      i_i2c_host_model.stop();
    end
    chk(index_o, 16'h0101, "index kept");
    $display("t_foreign done");
  endtask

  // Port disabled: own address is ignored.
  task automatic t_enable();
    comms_enable_in_i = 1'b0;
    i_i2c_host_model.tick(10);
    i_i2c_host_model.start();
    send(DEV_ADDR_WR, 1'b0);
    i_i2c_host_model.stop();
    comms_enable_in_i = 1'b1;
    i_i2c_host_model.tick(10);
    $display("t_enable done");
  endtask

  // Port reset clears the index but keeps stored data.
  task automatic t_preset();
    set_idx(16'h0010);
    i_i2c_host_model.stop();
    port_reset_i = 1'b1;
    i_i2c_host_model.tick(10);
    port_reset_i = 1'b0;
    i_i2c_host_model.tick(10);
    chk(index_o, 16'h0000, "index after port reset");
    t_read(1);
    $display("t_preset done");
  endtask

  // A 25 ns dip on data while the clock is high is not a start.
  task automatic t_glitch();
    glitch = 1'b1;
    @(negedge clk_i);
    glitch = 1'b0;
    i_i2c_host_model.tick(20);
    chk({15'h0, busy_o}, 16'h0, "busy after spike");
    $display("t_glitch done");
  endtask

  // Watchdog that cuts a hang short.
  initial
  begin
    repeat (100000) @(posedge clk_i);
    fail_count++;
    $display("[ERR] %0t run time limit", $time);
    tally_and_finish();
  end

  // Main sequence.
  initial
  begin
    nrst_i            = 1'b0;
    port_reset_i      = 1'b0;
    comms_enable_in_i = 1'b1;
    glitch            = 1'b0;
    repeat (20) @(negedge clk_i);
    nrst_i = 1'b1;
    i_i2c_host_model.tick(10);
    t_glitch();
    t_write();
    t_read(3);
    t_foreign();
    t_enable();
    t_preset();
    tally_and_finish();
  end
endmodule
